// ### verilog/ptc_port_two.sv
// register file and pin steering of one 8-bit bidirectional port
// assumes an avalon-mm master on core_clk and pads that resolve the
// level from pin_oe, pin_out and the pull-up request
// pins arrive asynchronously; the serial peripherals share core_clk
// the serial route register is local and gates every secondary function
//
// Operation
// - in output mode a latch bit 0 drives low, 1 drives high; latch resets 0
// - direction bit 0 makes pin input, 1 output; read-write, resets 0
// - function bits 5,4,3,2,0 route serial signals when 1; bits 7,6,1 read 0
// - drive bits 7,6,5,2,1,0 pick push-pull 0 or open-drain 1; 4,3 read 0
// - pull-up connects only for input or open-drain pins; bits 4,3 read 0
// - pins 0-2,5-7 read level if input or open-drain, else 0
// - pins 3 and 4 always read the actual pin level
// - input pins 5,2 feed serial clock, 4 serial data, 1 uart receive
// - serial routing also needs the separate serial select setting
//
// The Avalon-MM slave port was left to the implementer.
`timescale 1ns/100ps
module ptc_port_two
  import ptc_pkg::*;
(
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic [15:0] avs_address,
  input wire logic [3:0] avs_byteenable,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [7:0] pin_in,
  output ptc_pads_t pads,
  input wire ptc_periph_out_t periph_out,
  output ptc_periph_in_t periph_in
);

  // software visible state
  logic [7:0] port_two_output_latch_r;
  logic [7:0] port_two_direction_r;
  logic [7:0] port_two_pullup_enable_r;
  logic [7:0] port_two_function_select_r;
  logic [7:0] port_two_drive_type_r;
  logic [2:0] serial_route_r;

  // bus handshake
  ptc_bus_state_t bus_state_r;
  ptc_bus_state_t bus_state_nxt;
  logic bus_req;
  logic bus_take;
  logic wr_take;
  logic lane0_wr;
  logic [7:0] wdata;
  logic [31:0] rdata_nxt;

  // register selects and write strobes
  logic sel_latch;
  logic sel_pin_read;
  logic sel_direction;
  logic sel_pullup;
  logic sel_function;
  logic sel_drive;
  logic sel_route;
  logic wr_latch;
  logic wr_direction;
  logic wr_pullup;
  logic wr_function;
  logic wr_drive;
  logic wr_route;

  // pin side
  logic [7:0] pin_level;
  logic [7:0] port_two_pin_read;
  logic [7:0] released;
  logic [7:0] alt_en;
  logic [7:0] alt_value;
  logic [7:0] alt_od;
  ptc_periph_in_t periph_in_nxt;

  // serial route fields
  logic route_en;
  logic clock_pin_b;
  logic low_pair_serial;

  assign route_en = serial_route_r[PTC_ROUTE_ENABLE_BIT];
  assign clock_pin_b = serial_route_r[PTC_ROUTE_CLOCK_PIN_BIT];
  assign low_pair_serial = serial_route_r[PTC_ROUTE_LOW_PAIR_BIT];

  // bus slave: one wait cycle, then the access completes
  // the fixed wait lets read data come from a flop, not the address mux

  // a request is pending while read or write is high
  assign bus_req = avs_read | avs_write;
  // the access is accepted in the acknowledge cycle only
  assign bus_take = bus_req & (bus_state_r == PTC_BUS_ACK);
  assign wr_take = bus_take & avs_write;
  // only byte lane 0 carries register data
  assign lane0_wr = wr_take & avs_byteenable[0];
  assign wdata = avs_writedata[7:0];

  // word decode of the bus address, one select per register
  assign sel_latch = ptc_hit(avs_address, PTC_IDX_OUTPUT_LATCH);
  assign sel_pin_read = ptc_hit(avs_address, PTC_IDX_PIN_READ);
  assign sel_direction = ptc_hit(avs_address, PTC_IDX_DIRECTION);
  assign sel_pullup = ptc_hit(avs_address, PTC_IDX_PULLUP_ENABLE);
  assign sel_function = ptc_hit(avs_address, PTC_IDX_FUNCTION_SELECT);
  assign sel_drive = ptc_hit(avs_address, PTC_IDX_DRIVE_TYPE);
  assign sel_route = ptc_hit(avs_address, PTC_IDX_SERIAL_ROUTE);

  // a write strobe is an accepted lane-0 write to the selected register
  assign wr_latch = lane0_wr & sel_latch;
  assign wr_direction = lane0_wr & sel_direction;
  assign wr_pullup = lane0_wr & sel_pullup;
  assign wr_function = lane0_wr & sel_function;
  assign wr_drive = lane0_wr & sel_drive;
  assign wr_route = lane0_wr & sel_route;

  // wait is low in the acknowledge cycle and whenever no request is pending
  assign avs_waitrequest = bus_req & (bus_state_r != PTC_BUS_ACK);

  // handshake state follows the request
  always_comb begin
    bus_state_nxt = PTC_BUS_IDLE;
    unique case (bus_state_r)
      PTC_BUS_IDLE: begin
        if (bus_req) begin
          bus_state_nxt = PTC_BUS_ACK;
        end
      end
      PTC_BUS_ACK: begin
        bus_state_nxt = PTC_BUS_IDLE;
      end
    endcase
  end

  // handshake state register
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      bus_state_r <= PTC_BUS_IDLE;
    end else begin
      bus_state_r <= bus_state_nxt;
    end
  end

  // register writes, one process per register
  // writes land only on the acknowledge edge, so a held request writes every second cycle

  // output latch, all bits writable
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      port_two_output_latch_r <= PTC_RST_OUTPUT_LATCH;
    end else if (wr_latch) begin
      port_two_output_latch_r <= wdata;
    end
  end

  // direction, all bits writable
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      port_two_direction_r <= PTC_RST_DIRECTION;
    end else if (wr_direction) begin
      port_two_direction_r <= wdata;
    end
  end

  // pull-up enable, bits 4 and 3 stay zero
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      port_two_pullup_enable_r <= PTC_RST_PULLUP_ENABLE;
    end else if (wr_pullup) begin
      port_two_pullup_enable_r <= wdata & PTC_MASK_PULLUP_ENABLE;
    end
  end

  // function select, bits 7, 6 and 1 stay zero
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      port_two_function_select_r <= PTC_RST_FUNCTION_SELECT;
    end else if (wr_function) begin
      port_two_function_select_r <= wdata & PTC_MASK_FUNCTION_SELECT;
    end
  end

  // drive type, bits 4 and 3 stay zero
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      port_two_drive_type_r <= PTC_RST_DRIVE_TYPE;
    end else if (wr_drive) begin
      port_two_drive_type_r <= wdata & PTC_MASK_DRIVE_TYPE;
    end
  end

  // serial route: enable, clock pin choice, low pair use
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      serial_route_r <= PTC_RST_SERIAL_ROUTE;
    end else if (wr_route) begin
      serial_route_r <= wdata[2:0];
    end
  end

  // register reads
  // unimplemented bits are masked at write time, so reads need no mask

  // read value mux; unmapped addresses read zero
  always_comb begin
    rdata_nxt = 32'h0000_0000;
    if (sel_latch) begin
      rdata_nxt[7:0] = port_two_output_latch_r;
    end else if (sel_pin_read) begin
      rdata_nxt[7:0] = port_two_pin_read;
    end else if (sel_direction) begin
      rdata_nxt[7:0] = port_two_direction_r;
    end else if (sel_pullup) begin
      rdata_nxt[7:0] = port_two_pullup_enable_r;
    end else if (sel_function) begin
      rdata_nxt[7:0] = port_two_function_select_r;
    end else if (sel_drive) begin
      rdata_nxt[7:0] = port_two_drive_type_r;
    end else if (sel_route) begin
      rdata_nxt[2:0] = serial_route_r;
    end
  end

  // read data captured in the wait cycle, held through the acknowledge
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read && bus_state_r == PTC_BUS_IDLE) begin
      avs_readdata <= rdata_nxt;
    end
  end

  // pin input path
  // pin levels pass the synchroniser before any read or steering

  ptc_pin_sync u_sync (
    .core_clk(core_clk),
    .resetn(resetn),
    .pin_async(pin_in),
    .pin_level(pin_level)
  );

  // pin read-back: level when released, zero when driving push-pull
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      released[i] = ptc_released(port_two_direction_r[i],
                                 port_two_drive_type_r[i]);
    end
    port_two_pin_read = pin_level & released;
    // pins 3 and 4 show the level under any setting
    port_two_pin_read = port_two_pin_read
                        | (pin_level & PTC_MASK_RAW_READ);
  end

  // secondary function steering onto the pins
  // steering sits ahead of the pad flops, so pads never glitch on a switch

  // a function takes its pin only when also routed
  assign alt_en = port_two_function_select_r & {8{route_en}};

  // source of each pin under its secondary function
  always_comb begin
    alt_value = 8'h00;
    alt_od = 8'h00;
    alt_value[PTC_PIN_TX] = low_pair_serial ? periph_out.serial_data_out
                                            : periph_out.uart_transmit;
    alt_value[PTC_PIN_CLK_A] = periph_out.serial_clock_out;
    alt_value[PTC_PIN_DATA] = periph_out.two_wire_mode
                              ? periph_out.two_wire_data_out
                              : periph_out.serial_data_out;
    alt_value[PTC_PIN_TW_CLK] = periph_out.two_wire_clock_out;
    alt_value[PTC_PIN_CLK_B] = periph_out.serial_clock_out;
    // in two-wire mode the two-wire lines never drive high
    alt_od[PTC_PIN_DATA] = periph_out.two_wire_mode;
    alt_od[PTC_PIN_TW_CLK] = periph_out.two_wire_mode;
  end

  // one output stage per pin
  for (genvar g = 0; g < 8; g++) begin : g_cell
    ptc_pin_cell u_cell (
      .core_clk(core_clk),
      .resetn(resetn),
      .dir(port_two_direction_r[g]),
      .latch(port_two_output_latch_r[g]),
      .open_drain(port_two_drive_type_r[g]),
      .pullup_req(port_two_pullup_enable_r[g]),
      .alt_en(alt_en[g]),
      .alt_value(alt_value[g]),
      .alt_od(alt_od[g]),
      .pin_out(pads.pin_out[g]),
      .pin_oe(pads.pin_oe[g]),
      .pin_pullup(pads.pin_pullup[g])
    );
  end

  // pin levels delivered to the serial peripherals
  // inputs idle high so an unrouted line looks released to the peripheral

  // input pins feed peripherals; idle high while not routed
  always_comb begin
    periph_in_nxt = '1;
    if (route_en) begin
      if (clock_pin_b) begin
        if (!port_two_direction_r[PTC_PIN_CLK_B]) begin
          periph_in_nxt.serial_clock_line =
            pin_level[PTC_PIN_CLK_B];
        end
      end else if (!port_two_direction_r[PTC_PIN_CLK_A]) begin
        periph_in_nxt.serial_clock_line = pin_level[PTC_PIN_CLK_A];
      end
      if (low_pair_serial) begin
        if (!port_two_direction_r[PTC_PIN_RX]) begin
          periph_in_nxt.serial_data_in = pin_level[PTC_PIN_RX];
        end
      end else begin
        if (!port_two_direction_r[PTC_PIN_TW_CLK]) begin
          periph_in_nxt.serial_data_in = pin_level[PTC_PIN_TW_CLK];
        end
        if (!port_two_direction_r[PTC_PIN_RX]) begin
          periph_in_nxt.uart_receive = pin_level[PTC_PIN_RX];
        end
      end
      // two-wire lines are read back in either direction
      if (port_two_function_select_r[PTC_PIN_TW_CLK]) begin
        periph_in_nxt.two_wire_clock = pin_level[PTC_PIN_TW_CLK];
      end
      if (port_two_function_select_r[PTC_PIN_DATA]) begin
        periph_in_nxt.two_wire_data = pin_level[PTC_PIN_DATA];
      end
    end
  end

  // registered peripheral inputs
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      periph_in <= '1;
    end else begin
      periph_in <= periph_in_nxt;
    end
  end

endmodule : ptc_port_two

// ### verilog/ptc_pkg.sv
// shared constants, types and helpers for the port two control block
// assumes a 10 MHz core clock and an avalon-mm byte-addressed register bus
package ptc_pkg;

  // register indices; the byte address is four times the index
  localparam logic [11:0] PTC_IDX_OUTPUT_LATCH = 12'h002;
  localparam logic [11:0] PTC_IDX_PIN_READ = 12'h00f;
  localparam logic [11:0] PTC_IDX_DIRECTION = 12'hf1c;
  localparam logic [11:0] PTC_IDX_PULLUP_ENABLE = 12'hf29;
  localparam logic [11:0] PTC_IDX_FUNCTION_SELECT = 12'hf36;
  localparam logic [11:0] PTC_IDX_DRIVE_TYPE = 12'hf43;
  localparam logic [11:0] PTC_IDX_SERIAL_ROUTE = 12'hf50;

  // values after reset
  localparam logic [7:0] PTC_RST_OUTPUT_LATCH = 8'h00;
  localparam logic [7:0] PTC_RST_DIRECTION = 8'h00;
  localparam logic [7:0] PTC_RST_PULLUP_ENABLE = 8'h00;
  localparam logic [7:0] PTC_RST_FUNCTION_SELECT = 8'h00;
  localparam logic [7:0] PTC_RST_DRIVE_TYPE = 8'h00;
  localparam logic [2:0] PTC_RST_SERIAL_ROUTE = 3'h0;
  localparam logic [7:0] PTC_RST_PIN_LEVEL = 8'h00;

  // implemented bits of the mixed registers
  localparam logic [7:0] PTC_MASK_FUNCTION_SELECT = 8'h3d;
  localparam logic [7:0] PTC_MASK_DRIVE_TYPE = 8'he7;
  localparam logic [7:0] PTC_MASK_PULLUP_ENABLE = 8'he7;
  // pins whose read-back always shows the pin level
  localparam logic [7:0] PTC_MASK_RAW_READ = 8'h18;

  // field positions in the serial route register
  localparam int PTC_ROUTE_ENABLE_BIT = 0;
  localparam int PTC_ROUTE_CLOCK_PIN_BIT = 1;
  localparam int PTC_ROUTE_LOW_PAIR_BIT = 2;

  // pin positions of the secondary functions
  localparam int PTC_PIN_TX = 0;
  localparam int PTC_PIN_RX = 1;
  localparam int PTC_PIN_CLK_A = 2;
  localparam int PTC_PIN_DATA = 3;
  localparam int PTC_PIN_TW_CLK = 4;
  localparam int PTC_PIN_CLK_B = 5;

  // bus handshake, gray coded
  typedef enum logic {
    PTC_BUS_IDLE = 1'b0,
    PTC_BUS_ACK = 1'b1
  } ptc_bus_state_t;

  // signals coming from the serial peripherals
  typedef struct packed {
    logic serial_clock_out;
    logic serial_data_out;
    logic uart_transmit;
    logic two_wire_clock_out;
    logic two_wire_data_out;
    logic two_wire_mode;
  } ptc_periph_out_t;

  // signals going to the serial peripherals
  typedef struct packed {
    logic serial_clock_line;
    logic serial_data_in;
    logic uart_receive;
    logic two_wire_clock;
    logic two_wire_data;
  } ptc_periph_in_t;

  // pad controls of the eight pins
  typedef struct packed {
    logic [7:0] pin_out;
    logic [7:0] pin_oe;
    logic [7:0] pin_pullup;
  } ptc_pads_t;

  // pin is not actively driven high: input or open drain
  function automatic logic ptc_released(input logic dir, input logic od);
    return ~dir | od;
  endfunction : ptc_released

  // word address decode of a byte address
  function automatic logic ptc_hit(input logic [15:0] addr,
                                   input logic [11:0] idx);
    return addr[15:2] == {2'b00, idx};
  endfunction : ptc_hit

endpackage : ptc_pkg

// ### verilog/ptc_pin_sync.sv
// three-stage synchroniser for the eight pin levels
// assumes asynchronous pin inputs sampled on core_clk
`timescale 1ns/100ps
module ptc_pin_sync
  import ptc_pkg::*;
(
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic [7:0] pin_async,
  output logic [7:0] pin_level
);

  logic [7:0] stage1_r;
  logic [7:0] stage2_r;
  logic [7:0] stage3_r;

  // capture chain; stage1 is read only by stage2
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      stage1_r <= PTC_RST_PIN_LEVEL;
      stage2_r <= PTC_RST_PIN_LEVEL;
      stage3_r <= PTC_RST_PIN_LEVEL;
    end else begin
      stage1_r <= pin_async;
      stage2_r <= stage1_r;
      stage3_r <= stage2_r;
    end
  end

  // a bit changes only once stages two and three agree
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      pin_level <= PTC_RST_PIN_LEVEL;
    end else begin
      for (int i = 0; i < 8; i++) begin
        if (stage2_r[i] == stage3_r[i]) begin
          pin_level[i] <= stage3_r[i];
        end
      end
    end
  end

endmodule : ptc_pin_sync

// ### verilog/ptc_pin_cell.sv
// output stage of one port pin: value, enable and pull-up request
// assumes the pad resolves the level from enable and pull-up outside
`timescale 1ns/100ps
module ptc_pin_cell
  import ptc_pkg::*;
(
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic dir,
  input wire logic latch,
  input wire logic open_drain,
  input wire logic pullup_req,
  input wire logic alt_en,
  input wire logic alt_value,
  input wire logic alt_od,
  output logic pin_out,
  output logic pin_oe,
  output logic pin_pullup
);

  logic value;
  logic od;

  // secondary function replaces the latch as source
  assign value = alt_en ? alt_value : latch;
  assign od = open_drain | (alt_en & alt_od);

  // registered pad controls; open drain only ever drives low
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      pin_out <= 1'b0;
      pin_oe <= 1'b0;
      pin_pullup <= 1'b0;
    end else begin
      pin_out <= value & ~od;
      pin_oe <= dir & (~od | ~value);
      pin_pullup <= pullup_req & ptc_released(dir, od);
    end
  end

endmodule : ptc_pin_cell

// ### verification/ptc_port_two_chk.sv
// concurrent checks on the ports of the port two control block
// assumes binding to ptc_port_two with one clock and synchronous reset
`timescale 1ns/100ps
module ptc_port_two_chk
  import ptc_pkg::*;
(
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic [15:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire ptc_pads_t pads
);
  localparam logic [15:0] A_PU = {2'b00, PTC_IDX_PULLUP_ENABLE, 2'b00};
  localparam logic [15:0] A_FSEL = {2'b00, PTC_IDX_FUNCTION_SELECT, 2'b00};
  localparam logic [15:0] A_DRV = {2'b00, PTC_IDX_DRIVE_TYPE, 2'b00};

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!resetn);

  // bus steps: the wait cycle, then the completing cycle
  sequence s_req;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence s_done;
    (avs_read || avs_write) && !avs_waitrequest;
  endsequence
  sequence s_rd(logic [15:0] a);
    avs_read && !avs_waitrequest && avs_address == a;
  endsequence

  AST_IDLE_NOWAIT:
    assert property (!(avs_read || avs_write) |-> !avs_waitrequest)
      else $error("waitrequest high while idle");
  AST_FIRST_WAIT:
    assert property ($rose(avs_read || avs_write) |-> s_req)
      else $error("new request not held off");
  AST_ONE_WAIT:
    assert property (s_req |=> s_done)
      else $error("request not done after one wait");
  AST_UPPER_ZERO:
    assert property (avs_readdata[31:8] == 24'h000000)
      else $error("upper read data not zero");
  AST_RDATA_HOLD:
    assert property ($changed(avs_readdata) |->
                     $past(avs_read && avs_waitrequest))
      else $error("read data moved without a read");
  AST_FSEL_RO:
    assert property (s_rd(A_FSEL) |->
                     avs_readdata[7:6] == 2'b00 && !avs_readdata[1])
      else $error("function select spare bits set");
  AST_DRV_RO:
    assert property (s_rd(A_DRV) |-> avs_readdata[4:3] == 2'b00)
      else $error("drive type spare bits set");
  AST_PU_RO:
    assert property (s_rd(A_PU) |-> avs_readdata[4:3] == 2'b00)
      else $error("pull-up spare bits set");
  AST_PU_MASK:
    assert property (pads.pin_pullup[4:3] == 2'b00)
      else $error("pull-up on pin 3 or 4");
  AST_NO_PULL_HIGH:
    assert property ((pads.pin_pullup & pads.pin_oe & pads.pin_out) == 8'h00)
      else $error("pull-up while driving high");
endmodule : ptc_port_two_chk

bind ptc_port_two ptc_port_two_chk u_ptc_port_two_chk (
  .core_clk(core_clk),
  .resetn(resetn),
  .avs_address(avs_address),
  .avs_read(avs_read),
  .avs_write(avs_write),
  .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest),
  .pads(pads)
);

// ### verification/ptc_pad_model.sv
// model of the eight external pins: pads, outside drivers and pull-ups
// assumes the pad controls of ptc_port_two and the core clock
`timescale 1ns/100ps
module ptc_pad_model
  import ptc_pkg::*;
(
  input wire logic core_clk,
  input wire ptc_pads_t pads,
  input wire logic [7:0] ext_en,
  input wire logic [7:0] ext_val,
  output logic [7:0] pin_wire
);
  logic [7:0] float_r;
  initial pin_wire = 8'h00;
  initial float_r = 8'h00;
  // device drive wins, then outside drive, then pull-up; a pin left
  // floating flips once to the inverse of its last level and holds it
  always @(posedge core_clk) begin
    for (int i = 0; i < 8; i++) begin
      if (pads.pin_oe[i] === 1'b1)
        pin_wire[i] <= pads.pin_out[i];
      else if (ext_en[i] === 1'b1)
        pin_wire[i] <= ext_val[i];
      else if (pads.pin_pullup[i] === 1'b1)
        pin_wire[i] <= 1'b1;
      else if (!float_r[i])
        pin_wire[i] <= ~pin_wire[i];
      float_r[i] <= pads.pin_oe[i] !== 1'b1 && ext_en[i] !== 1'b1
                    && pads.pin_pullup[i] !== 1'b1;
    end
  end
endmodule : ptc_pad_model

// ### verification/ptc_port_two_tb.sv
// self-checking bench for the port two control block
// assumes ptc_port_two, the pad model and the bound checker
`timescale 1ns/100ps
module ptc_port_two_tb
  import ptc_pkg::*;
;
  logic core_clk;
  logic resetn;
  logic [15:0] avs_address;
  logic [3:0] avs_byteenable;
  logic avs_read;
  logic avs_write;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [7:0] pin_wire;
  logic [7:0] ext_en;
  logic [7:0] ext_val;
  ptc_pads_t pads;
  ptc_periph_out_t periph_out;
  ptc_periph_in_t periph_in;
  int bad_count;
  int compares;
  localparam logic [15:0] A_LAT = {2'b00, PTC_IDX_OUTPUT_LATCH, 2'b00};
  localparam logic [15:0] A_PRD = {2'b00, PTC_IDX_PIN_READ, 2'b00};
  localparam logic [15:0] A_DIR = {2'b00, PTC_IDX_DIRECTION, 2'b00};
  localparam logic [15:0] A_PU = {2'b00, PTC_IDX_PULLUP_ENABLE, 2'b00};
  localparam logic [15:0] A_FSEL = {2'b00, PTC_IDX_FUNCTION_SELECT, 2'b00};
  localparam logic [15:0] A_DRV = {2'b00, PTC_IDX_DRIVE_TYPE, 2'b00};
  localparam logic [15:0] A_RTE = {2'b00, PTC_IDX_SERIAL_ROUTE, 2'b00};
  localparam logic [15:0] AD [5] = '{A_LAT, A_DIR, A_FSEL, A_DRV, A_PU};
  localparam logic [7:0] MK [5] = '{8'hff, 8'hff, 8'h3d, 8'he7, 8'he7};

  ptc_port_two u_ptc_port_two (
    .core_clk(core_clk), .resetn(resetn), .avs_address(avs_address),
    .avs_byteenable(avs_byteenable), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .pin_in(pin_wire), .pads(pads), .periph_out(periph_out),
    .periph_in(periph_in)
  );
  ptc_pad_model u_ptc_pad_model (
    .core_clk(core_clk), .pads(pads), .ext_en(ext_en),
    .ext_val(ext_val), .pin_wire(pin_wire)
  );

  // free-running core clock
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  task end_of_test;
    $display("mismatches %0d compares %0d", bad_count, compares);
    if (bad_count == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : end_of_test

  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // one avalon transfer, held until waitrequest is seen low
  task xfer(input logic w, input logic [15:0] a, input logic [7:0] d,
            output logic [31:0] q);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= {24'h000000, d};
    avs_write <= w;
    avs_read <= ~w;
    // waitrequest and read data are taken at the same rising edge
    @(posedge core_clk);
    while (avs_waitrequest !== 1'b0 && n < 20) begin
      n++;
      @(posedge core_clk);
    end
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (n < 20) begin
      @(posedge core_clk);
    end else begin
      bad_count++;
      end_of_test;
    end
  endtask : xfer

  task wr(input logic [15:0] a, input logic [7:0] d);
    logic [31:0] q;
    xfer(1'b1, a, d, q);
  endtask : wr

  task rd(input logic [15:0] a, input logic [7:0] e);
    logic [31:0] q;
    xfer(1'b0, a, 8'h00, q);
    chk(q, {24'h000000, e});
  endtask : rd

  // pads, sync and model need a few cycles to follow a write
  task settle;
    repeat (8) @(posedge core_clk);
  endtask : settle

  task t_reset;
    rd(A_LAT, 8'h00);
    rd(A_DIR, 8'h00);
    rd(A_FSEL, 8'h00);
    rd(A_DRV, 8'h00);
    rd(A_PU, 8'h00);
    rd(A_RTE, 8'h00);
    rd(16'h0100, 8'h00);
  endtask : t_reset

  // all-ones writes keep only implemented bits; disabled byte ignored
  task t_masks;
    for (int i = 0; i < 5; i++) begin
      wr(AD[i], 8'hff);
      rd(AD[i], MK[i]);
      wr(AD[i], 8'h00);
    end
    avs_byteenable <= 4'h0;
    wr(A_LAT, 8'hff);
    avs_byteenable <= 4'h1;
    rd(A_LAT, 8'h00);
  endtask : t_masks

  task t_push_pull;
    wr(A_DIR, 8'hff);
    wr(A_PU, 8'hff);
    wr(A_LAT, 8'h5a);
    settle;
    chk({8'h00, pads}, {8'h00, 8'h5a, 8'hff, 8'h00});
    rd(A_PRD, 8'h18);
  endtask : t_push_pull

  task t_open_drain;
    wr(A_DRV, 8'he7);
    wr(A_LAT, 8'hff);
    settle;
    chk({8'h00, pads}, {8'h00, 8'h18, 8'h18, 8'he7});
    rd(A_PRD, 8'hff);
    wr(A_LAT, 8'h00);
    settle;
    chk({8'h00, pads}, {8'h00, 8'h00, 8'hff, 8'he7});
    rd(A_PRD, 8'h00);
  endtask : t_open_drain

  task t_input;
    wr(A_DIR, 8'h00);
    ext_val <= 8'h3c;
    ext_en <= 8'hff;
    settle;
    chk({16'h0, pads.pin_oe, pads.pin_pullup}, 32'h00e7);
    rd(A_PRD, 8'h3c);
    ext_en <= 8'he7;
    wr(A_DRV, 8'h00);
    wr(A_LAT, 8'hff);
    wr(A_DIR, 8'h18);
    settle;
    rd(A_PRD, 8'h3c);
  endtask : t_input

  // function bit alone leaves the port function until routing is enabled
  task t_route;
    ext_val <= 8'h00;
    ext_en <= 8'h16;
    periph_out.uart_transmit <= 1'b1;
    wr(A_DIR, 8'h01);
    wr(A_FSEL, 8'h01);
    wr(A_LAT, 8'h00);
    settle;
    chk({31'h0, pads.pin_out[0]}, 32'h0);
    chk({27'h0, periph_in}, 32'h1f);
    wr(A_RTE, 8'h01);
    settle;
    chk({31'h0, pads.pin_out[0]}, 32'h1);
    chk({29'h0, periph_in.serial_clock_line, periph_in.serial_data_in,
         periph_in.uart_receive}, 32'h0);
    periph_out.uart_transmit <= 1'b0;
    settle;
    chk({31'h0, pads.pin_out[0]}, 32'h0);
  endtask : t_route

  // serial mode: clock from pin 5, pins 0/1 serial, two-wire open drain
  task t_serial;
    ext_val <= 8'h22;
    ext_en <= 8'h2e;
    periph_out.serial_data_out <= 1'b1;
    periph_out.two_wire_mode <= 1'b1;
    periph_out.two_wire_data_out <= 1'b1;
    periph_out.two_wire_clock_out <= 1'b0;
    wr(A_DIR, 8'h19);
    wr(A_FSEL, 8'h19);
    wr(A_RTE, 8'h07);
    settle;
    chk({8'h00, pads}, {8'h00, 8'h01, 8'h11, 8'he6});
    chk({27'h0, periph_in}, 32'h1c);
    rd(A_PRD, 8'he2);
  endtask : t_serial

  // reset, then every scenario in turn
  initial begin
    resetn = 1'b0;
    avs_address = 16'h0000;
    avs_byteenable = 4'h1;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    ext_en = 8'h00;
    ext_val = 8'h00;
    periph_out = '0;
    bad_count = 0;
    compares = 0;
    repeat (20) @(posedge core_clk);
    resetn <= 1'b1;
    @(posedge core_clk);
    t_reset;
    t_masks;
    t_push_pull;
    t_open_drain;
    t_input;
    t_route;
    t_serial;
    end_of_test;
  end
endmodule : ptc_port_two_tb
